// file: ifd_map.svh
// Register offsets, field codes, opcodes and reset values of the field decoder
`ifndef IFD_MAP_SVH
`define IFD_MAP_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define IFD_INSTR_LO_OFS   8'h00
`define IFD_INSTR_HI_OFS   8'h04
`define IFD_BASE_OFS       8'h08
`define IFD_INDEX_OFS      8'h0c
`define IFD_FLAGS_OFS      8'h10
`define IFD_COUNT_OFS      8'h14
`define IFD_CTRL_OFS       8'h18
`define IFD_RES0_OFS       8'h1c
`define IFD_RES1_OFS       8'h20
`define IFD_RES2_OFS       8'h24

// ----------------------------------------
// Field codes
// ----------------------------------------
`define IFD_MOD_NODISP     2'b00
`define IFD_MOD_DISP8      2'b01
`define IFD_MOD_DISP16     2'b10
`define IFD_MOD_REG        2'b11
`define IFD_RM_DIRECT      3'b110
`define IFD_CTRL_GO_BIT    0
`define IFD_SHIFT_ONE      8'h01

// ----------------------------------------
// Flag word positions
// ----------------------------------------
`define IFD_BIT_CARRY      0
`define IFD_BIT_PARITY     2
`define IFD_BIT_AUX        4
`define IFD_BIT_ZERO       6
`define IFD_BIT_SIGN       7
`define IFD_BIT_TRAP       8
`define IFD_BIT_INTEN      9
`define IFD_BIT_DIR        10
`define IFD_BIT_OVER       11
`define IFD_FLAGS_MASK     16'h0fd5
`define IFD_FLAGS_RST      16'h0000

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define IFD_OP_JMP_NEAR    8'he9
`define IFD_OP_JMP_SHORT   8'heb
`define IFD_OP_JMP_FAR     8'hea
`define IFD_OP_CALL_NEAR   8'he8
`define IFD_OP_CALL_FAR    8'h9a
`define IFD_OP_RET_N       8'hc3
`define IFD_OP_RET_NI      8'hc2
`define IFD_OP_RET_F       8'hcb
`define IFD_OP_RET_FI      8'hca
`define IFD_OP_INT_N       8'hcd
`define IFD_OP_INT_3       8'hcc
`define IFD_OP_INT_OVF     8'hce
`define IFD_OP_INT_RET     8'hcf
`define IFD_OP_IMM_SX      8'h83

`endif

// file: ifd_pkg.sv
// Types shared by the instruction field decoder
package ifd_pkg;

	typedef enum logic [4:0] {
		IFD_K_OTHER     = 5'b00000,
		IFD_K_SEG_PFX   = 5'b00001,
		IFD_K_REP_PFX   = 5'b00010,
		IFD_K_JMP_NEAR  = 5'b00011,
		IFD_K_JMP_SHORT = 5'b00100,
		IFD_K_JMP_FAR   = 5'b00101,
		IFD_K_JCC       = 5'b00110,
		IFD_K_CALL_NEAR = 5'b00111,
		IFD_K_CALL_FAR  = 5'b01000,
		IFD_K_RET_N     = 5'b01001,
		IFD_K_RET_NI    = 5'b01010,
		IFD_K_RET_F     = 5'b01011,
		IFD_K_RET_FI    = 5'b01100,
		IFD_K_INT_N     = 5'b01101,
		IFD_K_INT_3     = 5'b01110,
		IFD_K_INT_OVF   = 5'b01111,
		IFD_K_INT_RET   = 5'b10000,
		IFD_K_SHIFT     = 5'b10001,
		IFD_K_LOOP      = 5'b10010
	} ifd_kind_type;

	typedef struct packed {
		logic [4:0]  rsvd;
		logic        rep_cont;
		logic        cond_true;
		logic        seg_ovr;
		logic [1:0]  seg;
		logic        rm_hi;
		logic [2:0]  rm_idx;
		logic        reg_hi;
		logic [2:0]  reg_idx;
		logic [1:0]  disp_len;
		logic        mem_op;
		logic        to_reg;
		logic        word;
		logic [3:0]  len;
		ifd_kind_type kind;
	} ifd_res_type;

	typedef struct packed {
		ifd_res_type res;
		logic [15:0] imm;
		logic [15:0] effective_address;
		logic [7:0]  shift_count;
	} ifd_dec_type;

endpackage : ifd_pkg

// file: ifd_top.sv
// Instruction field decoder with APB register access
`timescale 1ns/100ps
`include "ifd_map.svh"

module ifd_top (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	output ifd_pkg::ifd_dec_type   dec_out
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic has_modrm(input logic [7:0] op);
		has_modrm = 1'b0;
		if (op[7:6] == 2'b00 && op[2] == 1'b0) begin
			has_modrm = 1'b1;
		end else if (op[7:4] == 4'h8 && op != `IFD_OP_CALL_FAR) begin
			has_modrm = 1'b1;
		end else if (op[7:1] == 7'b1100011 || op[7:1] == 7'b1100010) begin
			has_modrm = 1'b1;
		end else if (op[7:2] == 6'b110100 || op[7:3] == 5'b11011) begin
			has_modrm = 1'b1;
		end else if (op[7:1] == 7'b1111011 || op[7:1] == 7'b1111111) begin
			has_modrm = 1'b1;
		end
	endfunction : has_modrm

	function automatic logic [2:0] imm_len(input logic [7:0] op, input logic [2:0] rg);
		imm_len = 3'd0;
		if (op[7:2] == 6'b100000) begin
			imm_len = (op[1:0] == 2'b01) ? 3'd2 : 3'd1;
		end else if (op[7:6] == 2'b00 && op[2:1] == 2'b10) begin
			imm_len = op[0] ? 3'd2 : 3'd1;
		end else if (op[7:1] == 7'b1100011) begin
			imm_len = op[0] ? 3'd2 : 3'd1;
		end else if (op[7:4] == 4'hb) begin
			imm_len = op[3] ? 3'd2 : 3'd1;
		end else if (op[7:1] == 7'b1111011 && rg == 3'b000) begin
			imm_len = op[0] ? 3'd2 : 3'd1;
		end else if (op[7:4] == 4'h7 || op == `IFD_OP_JMP_SHORT) begin
			imm_len = 3'd1;
		end else if (op[7:2] == 6'b111000 || op[7:2] == 6'b111001) begin
			imm_len = 3'd1;
		end else if (op == `IFD_OP_INT_N) begin
			imm_len = 3'd1;
		end else if (op == `IFD_OP_JMP_NEAR || op == `IFD_OP_CALL_NEAR) begin
			imm_len = 3'd2;
		end else if (op == `IFD_OP_RET_NI || op == `IFD_OP_RET_FI) begin
			imm_len = 3'd2;
		end else if (op[7:2] == 6'b101000) begin
			imm_len = 3'd2;
		end else if (op == `IFD_OP_JMP_FAR || op == `IFD_OP_CALL_FAR) begin
			imm_len = 3'd4;
		end
	endfunction : imm_len

	function automatic logic [15:0] ea_base(input logic [2:0] rm,
		input logic [15:0] bx, input logic [15:0] bp,
		input logic [15:0] si, input logic [15:0] di);
		case (rm)
			3'b000: ea_base = bx + si;
			3'b001: ea_base = bx + di;
			3'b010: ea_base = bp + si;
			3'b011: ea_base = bp + di;
			3'b100: ea_base = si;
			3'b101: ea_base = di;
			3'b110: ea_base = bp;
			default: ea_base = bx;
		endcase
	endfunction : ea_base

	function automatic logic [3:0] reg_sel(input logic w, input logic [2:0] code);
		reg_sel = w ? {1'b0, code} : {code[2], 1'b0, code[1:0]};
	endfunction : reg_sel

	function automatic logic cond_eval(input logic [3:0] cc, input logic [15:0] f);
		logic lt;
		lt = f[`IFD_BIT_SIGN] ^ f[`IFD_BIT_OVER];
		case (cc[3:1])
			3'd0: cond_eval = f[`IFD_BIT_OVER];
			3'd1: cond_eval = f[`IFD_BIT_CARRY];
			3'd2: cond_eval = f[`IFD_BIT_ZERO];
			3'd3: cond_eval = f[`IFD_BIT_CARRY] | f[`IFD_BIT_ZERO];
			3'd4: cond_eval = f[`IFD_BIT_SIGN];
			3'd5: cond_eval = f[`IFD_BIT_PARITY];
			3'd6: cond_eval = lt;
			default: cond_eval = lt | f[`IFD_BIT_ZERO];
		endcase
		cond_eval = cond_eval ^ cc[0];
	endfunction : cond_eval

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [31:0] instr_lo_r;
	logic [15:0] instr_hi_r;
	logic [31:0] base_r;
	logic [31:0] index_r;
	logic [15:0] flags_r;
	logic [7:0]  count_low_byte_r;
	logic [1:0]  seg_r;
	logic        seg_v_r;
	ifd_pkg::ifd_dec_type dec_r;
	ifd_pkg::ifd_dec_type dec_nxt;

	logic        acc;
	logic        wr;
	logic        go;
	logic [7:0]  ib [0:5];

	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign go = wr && paddr == `IFD_CTRL_OFS && pwdata[`IFD_CTRL_GO_BIT];
	assign pready = 1'b1;
	assign dec_out = dec_r;

	assign ib[0] = instr_lo_r[7:0];
	assign ib[1] = instr_lo_r[15:8];
	assign ib[2] = instr_lo_r[23:16];
	assign ib[3] = instr_lo_r[31:24];
	assign ib[4] = instr_hi_r[7:0];
	assign ib[5] = instr_hi_r[15:8];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			instr_lo_r <= 32'h0;
			instr_hi_r <= 16'h0;
			base_r <= 32'h0;
			index_r <= 32'h0;
			count_low_byte_r <= 8'h0;
		end else if (wr) begin
			if (paddr == `IFD_INSTR_LO_OFS) begin
				instr_lo_r <= pwdata;
			end else if (paddr == `IFD_INSTR_HI_OFS) begin
				instr_hi_r <= pwdata[15:0];
			end else if (paddr == `IFD_BASE_OFS) begin
				base_r <= pwdata;
			end else if (paddr == `IFD_INDEX_OFS) begin
				index_r <= pwdata;
			end else if (paddr == `IFD_COUNT_OFS) begin
				count_low_byte_r <= pwdata[7:0];
			end
		end
	end

	// Flag word kept as one 16-bit object
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_r <= `IFD_FLAGS_RST;
		end else if (wr && paddr == `IFD_FLAGS_OFS) begin
			flags_r <= pwdata[15:0] & `IFD_FLAGS_MASK;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_comb begin
		prdata = 32'h0;
		pslverr = 1'b0;
		if (paddr == `IFD_INSTR_LO_OFS) begin
			prdata = instr_lo_r;
		end else if (paddr == `IFD_INSTR_HI_OFS) begin
			prdata = {16'h0, instr_hi_r};
		end else if (paddr == `IFD_BASE_OFS) begin
			prdata = base_r;
		end else if (paddr == `IFD_INDEX_OFS) begin
			prdata = index_r;
		end else if (paddr == `IFD_FLAGS_OFS) begin
			prdata = {16'h0, flags_r};
		end else if (paddr == `IFD_COUNT_OFS) begin
			prdata = {24'h0, count_low_byte_r};
		end else if (paddr == `IFD_CTRL_OFS) begin
			prdata = {29'h0, seg_v_r, seg_r};
		end else if (paddr == `IFD_RES0_OFS) begin
			prdata = dec_r.res;
		end else if (paddr == `IFD_RES1_OFS) begin
			prdata = {dec_r.imm, dec_r.effective_address};
		end else if (paddr == `IFD_RES2_OFS) begin
			prdata = {24'h0, dec_r.shift_count};
		end else begin
			pslverr = acc;
		end
	end

	// ----------------------------------------
	// Field decode
	// ----------------------------------------
	logic [7:0]  op;
	logic [1:0]  md;
	logic [2:0]  rg;
	logic [2:0]  rm;
	logic        hm;
	logic [1:0]  dl;
	logic [2:0]  il;
	logic [2:0]  ip;
	logic [15:0] disp;
	logic        sx;
	logic [3:0]  reg_code;
	logic [3:0]  rm_code;

	assign op = ib[0];
	assign md = ib[1][7:6];
	assign rg = ib[1][5:3];
	assign rm = ib[1][2:0];
	assign hm = has_modrm(op);
	assign il = imm_len(op, rg);
	assign ip = 3'd1 + {2'b00, hm} + {1'b0, dl};
	assign reg_code = reg_sel(op[0], rg);
	assign rm_code = reg_sel(op[0], rm);

	always_comb begin
		dl = 2'd0;
		if (hm) begin
			case (md)
				`IFD_MOD_NODISP: dl = (rm == `IFD_RM_DIRECT) ? 2'd2 : 2'd0;
				`IFD_MOD_DISP8:  dl = 2'd1;
				`IFD_MOD_DISP16: dl = 2'd2;
				default:         dl = 2'd0;
			endcase
		end
	end

	always_comb begin
		disp = 16'h0;
		if (dl == 2'd1) begin
			disp = {{8{ib[2][7]}}, ib[2]};
		end else if (dl == 2'd2) begin
			disp = {ib[3], ib[2]};
		end
	end

	assign sx = (op == `IFD_OP_IMM_SX) || op[7:4] == 4'h7 || op == `IFD_OP_JMP_SHORT
		|| op[7:2] == 6'b111000;

	always_comb begin
		dec_nxt = '0;
		dec_nxt.res.kind = ifd_pkg::IFD_K_OTHER;
		dec_nxt.res.len = {1'b0, 3'd1} + {3'b000, hm} + {2'b00, dl} + {1'b0, il};
		dec_nxt.res.word = op[0];
		dec_nxt.res.to_reg = hm & op[1];
		dec_nxt.res.mem_op = hm && md != `IFD_MOD_REG;
		dec_nxt.res.disp_len = dl;
		dec_nxt.res.reg_hi = reg_code[3];
		dec_nxt.res.reg_idx = reg_code[2:0];
		dec_nxt.res.rm_hi = rm_code[3];
		dec_nxt.res.rm_idx = rm_code[2:0];
		dec_nxt.res.seg = seg_r;
		dec_nxt.res.seg_ovr = seg_v_r && dec_nxt.res.mem_op;
		dec_nxt.res.rep_cont = 1'b1;
		if (dec_nxt.res.mem_op) begin
			if (md == `IFD_MOD_NODISP && rm == `IFD_RM_DIRECT) begin
				dec_nxt.effective_address = disp;
			end else begin
				dec_nxt.effective_address = ea_base(rm, base_r[15:0], base_r[31:16],
					index_r[15:0], index_r[31:16]) + disp;
			end
		end
		if (il == 3'd1) begin
			dec_nxt.imm = sx ? {{8{ib[ip][7]}}, ib[ip]} : {8'h0, ib[ip]};
		end else if (il != 3'd0) begin
			dec_nxt.imm = {ib[3'(ip + 3'd1)], ib[ip]};
		end
		if (op[7:2] == 6'b110100) begin
			dec_nxt.res.kind = ifd_pkg::IFD_K_SHIFT;
			dec_nxt.shift_count = op[1] ? count_low_byte_r : `IFD_SHIFT_ONE;
		end else if (op[7:4] == 4'h7) begin
			dec_nxt.res.kind = ifd_pkg::IFD_K_JCC;
			dec_nxt.res.cond_true = cond_eval(op[3:0], flags_r);
		end else if (op[7:2] == 6'b111000) begin
			dec_nxt.res.kind = ifd_pkg::IFD_K_LOOP;
		end else if (op[7:5] == 3'b001 && op[2:0] == 3'b110) begin
			dec_nxt.res.kind = ifd_pkg::IFD_K_SEG_PFX;
			dec_nxt.res.len = 4'd1;
		end else if (op[7:1] == 7'b1111001) begin
			dec_nxt.res.kind = ifd_pkg::IFD_K_REP_PFX;
			dec_nxt.res.len = 4'd1;
			if (ib[1][7:1] == 7'b1010011 || ib[1][7:1] == 7'b1010111) begin
				dec_nxt.res.rep_cont = op[0] == flags_r[`IFD_BIT_ZERO];
			end
		end else begin
			case (op)
				`IFD_OP_JMP_NEAR:  dec_nxt.res.kind = ifd_pkg::IFD_K_JMP_NEAR;
				`IFD_OP_JMP_SHORT: dec_nxt.res.kind = ifd_pkg::IFD_K_JMP_SHORT;
				`IFD_OP_JMP_FAR:   dec_nxt.res.kind = ifd_pkg::IFD_K_JMP_FAR;
				`IFD_OP_CALL_NEAR: dec_nxt.res.kind = ifd_pkg::IFD_K_CALL_NEAR;
				`IFD_OP_CALL_FAR:  dec_nxt.res.kind = ifd_pkg::IFD_K_CALL_FAR;
				`IFD_OP_RET_N:     dec_nxt.res.kind = ifd_pkg::IFD_K_RET_N;
				`IFD_OP_RET_NI:    dec_nxt.res.kind = ifd_pkg::IFD_K_RET_NI;
				`IFD_OP_RET_F:     dec_nxt.res.kind = ifd_pkg::IFD_K_RET_F;
				`IFD_OP_RET_FI:    dec_nxt.res.kind = ifd_pkg::IFD_K_RET_FI;
				`IFD_OP_INT_N:     dec_nxt.res.kind = ifd_pkg::IFD_K_INT_N;
				`IFD_OP_INT_3:     dec_nxt.res.kind = ifd_pkg::IFD_K_INT_3;
				`IFD_OP_INT_OVF:   dec_nxt.res.kind = ifd_pkg::IFD_K_INT_OVF;
				`IFD_OP_INT_RET:   dec_nxt.res.kind = ifd_pkg::IFD_K_INT_RET;
				default:           dec_nxt.res.kind = ifd_pkg::IFD_K_OTHER;
			endcase
		end
	end

	// ----------------------------------------
	// Result and segment state
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dec_r <= '0;
		end else if (go) begin
			dec_r <= dec_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_r <= 2'b00;
			seg_v_r <= 1'b0;
		end else if (go) begin
			seg_r <= op[4:3];
			seg_v_r <= dec_nxt.res.kind == ifd_pkg::IFD_K_SEG_PFX;
		end
	end

	// ----------------------------------------
	// Assertions and cover properties
	// ----------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	width_bit_a: assert property (go |=> dec_r.res.word == $past(op[0]))
		else $error("width bit not reflected");
	dir_bit_a: assert property (go && hm |=> dec_r.res.to_reg == $past(op[1]))
		else $error("direction bit not reflected");
	rm_reg_a: assert property (go && hm && md == 2'b11 |=> !dec_r.res.mem_op && dec_r.res.disp_len == 2'd0)
		else $error("register mode made memory access");
	direct_addr_a: assert property (go && hm && md == 2'b00 && rm == 3'b110
		|=> dec_r.effective_address == {$past(ib[3]), $past(ib[2])})
		else $error("direct address wrong");
	disp8_a: assert property (go && hm && md == 2'b01 |=> dec_r.res.disp_len == 2'd1)
		else $error("one byte displacement length wrong");
	near_jmp_a: assert property (go && op == 8'he9
		|=> dec_r.res.kind == ifd_pkg::IFD_K_JMP_NEAR && dec_r.res.len == 4'd3)
		else $error("near jump decode wrong");
	ret_imm_a: assert property (go && op == 8'hc2
		|=> dec_r.res.kind == ifd_pkg::IFD_K_RET_NI && dec_r.res.len == 4'd3)
		else $error("near return with immediate wrong");
	int_type_a: assert property (go && op == 8'hcd
		|=> dec_r.res.kind == ifd_pkg::IFD_K_INT_N && dec_r.res.len == 4'd2)
		else $error("typed interrupt decode wrong");
	shift_cnt_a: assert property (go && op[7:1] == 7'b1101001
		|=> dec_r.shift_count == $past(count_low_byte_r))
		else $error("shift count not from count low byte");
	imm_sx_a: assert property (go && op == 8'h83 && md == 2'b11
		|=> dec_r.imm == {{8{$past(ib[2][7])}}, $past(ib[2])})
		else $error("immediate byte not sign extended");
	seg_use_a: assert property (go && seg_v_r && hm && md != 2'b11 ##1 1
		|-> dec_r.res.seg_ovr && dec_r.res.seg == $past(seg_r))
		else $error("segment override not applied");

	jcc_cov_c: cover property (go && op[7:4] == 4'h7 ##1 dec_r.res.cond_true);
	seg_cov_c: cover property (go && op == 8'h3e ##[1:12] go && hm && md == 2'b00);
	rep_cov_c: cover property (go && op == 8'hf3 && ib[1] == 8'ha6);
	far_cov_c: cover property (go && op == 8'h9a);

endmodule : ifd_top

// file: ifd_apb_host.sv
// APB master model that stands in for software on the register side
`timescale 1ns/100ps

module ifd_apb_host (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	output logic             tmo
);

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		tmo = 1'b0;
	end

	// ----------------------------------------
	// One transfer, setup then access until pready
	// ----------------------------------------
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 16) tmo <= 1'b1;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer

endmodule : ifd_apb_host

// file: cpu_instruction_field_decoder_test.sv
// Self-checking bench of the instruction field decoder
`timescale 1ns/100ps

module cpu_instruction_field_decoder_test;

	logic                 pclk;
	logic                 presetn;
	logic                 psel;
	logic                 penable;
	logic                 pwrite;
	logic [7:0]           paddr;
	logic [31:0]          pwdata;
	logic [31:0]          prdata;
	logic                 pready;
	logic                 pslverr;
	logic                 tmo;
	ifd_pkg::ifd_dec_type dec;
	int                   errors;
	int                   checked;
	logic [31:0]          q;
	logic                 e;

	ifd_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dec_out(dec));

	ifd_apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tmo(tmo));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task c(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, x, g);
		end
	endtask : c

	task wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, q, e);
	endtask : wr

	task rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, q, e);
	endtask : rd

	task d(input logic [47:0] b);
		wr(8'h00, b[31:0]);
		wr(8'h04, {16'h0, b[47:32]});
		wr(8'h18, 32'h1);
		@(negedge pclk);
	endtask : d

	task tally_and_finish;
		if (errors == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	always @(posedge tmo) begin
		errors++;
		tally_and_finish();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task t_regs;
		rd(8'h1c);
		c("res0", 32'h0, q);
		wr(8'h10, 32'hffff_ffff);
		rd(8'h10);
		c("flags", 32'h0fd5, q);
		rd(8'h40);
		c("unmapped err", 32'h1, {31'h0, e});
		c("unmapped data", 32'h0, q);
	endtask : t_regs

	task t_ops;
		logic [23:0] b[12];
		logic [4:0]  k[12];
		logic [3:0]  n[12];
		logic [16:0] m[12];
		b = '{24'h0012e9, 24'h80eb, 24'hc3, 24'h1234c2, 24'hcb, 24'h5678ca,
			24'h21cd, 24'hcc, 24'hce, 24'hcf, 24'h56789a, 24'h0034e8};
		k = '{5'h03, 5'h04, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10,
			5'h08, 5'h07};
		n = '{4'h3, 4'h2, 4'h1, 4'h3, 4'h1, 4'h3, 4'h2, 4'h1, 4'h1, 4'h1, 4'h5, 4'h3};
		m = '{17'h10012, 17'h1ff80, 17'h0, 17'h11234, 17'h0, 17'h15678, 17'h10021,
			17'h0, 17'h0, 17'h0, 17'h15678, 17'h10034};
		for (int i = 0; i < 12; i++) begin
			d({24'h0, b[i]});
			c("kind", k[i], dec.res.kind);
			c("len", n[i], dec.res.len);
			if (m[i][16]) c("imm", m[i][15:0], dec.imm);
		end
	endtask : t_ops

	task t_modes;
		logic [15:0] s[8];
		s = '{16'h1030, 16'h1400, 16'h2030, 16'h2400, 16'h0030, 16'h0400, 16'h2000,
			16'h1000};
		for (int r = 0; r < 8; r++) begin
			d({16'h0, 8'hff, 2'b01, 3'b000, r[2:0], 8'h8b});
			c("ea", s[r] - 16'h1, dec.effective_address);
			c("len", 4'h3, dec.res.len);
			c("word", 1'b1, dec.res.word);
			c("to_reg", 1'b1, dec.res.to_reg);
			c("mem", 1'b1, dec.res.mem_op);
		end
		d(48'h5678068b);
		c("ea direct", 16'h5678, dec.effective_address);
		c("len", 4'h4, dec.res.len);
		d(48'h078b);
		c("ea nodisp", 16'h1000, dec.effective_address);
		c("len", 4'h2, dec.res.len);
		d(48'h12348688);
		c("ea disp16", 16'h3234, dec.effective_address);
		c("len", 4'h4, dec.res.len);
		c("word", 1'b0, dec.res.word);
		c("to_reg", 1'b0, dec.res.to_reg);
	endtask : t_modes

	task t_reg;
		d(48'hc38b);
		c("mem", 1'b0, dec.res.mem_op);
		c("rm", 3'h3, dec.res.rm_idx);
		c("len", 4'h2, dec.res.len);
		d(48'he78b);
		c("reg", 4'h4, {dec.res.reg_hi, dec.res.reg_idx});
		c("rm", 4'h7, {dec.res.rm_hi, dec.res.rm_idx});
		d(48'he78a);
		c("reg", 4'h8, {dec.res.reg_hi, dec.res.reg_idx});
		c("rm", 4'hb, {dec.res.rm_hi, dec.res.rm_idx});
	endtask : t_reg

	task t_imm;
		d(48'hffc083);
		c("imm sx", 16'hffff, dec.imm);
		c("len", 4'h3, dec.res.len);
		d(48'h1234054081);
		c("imm", 16'h1234, dec.imm);
		c("ea", 16'h1035, dec.effective_address);
		c("len", 4'h5, dec.res.len);
		rd(8'h20);
		c("res1", 32'h1234_1035, q);
	endtask : t_imm

	task t_shift;
		wr(8'h14, 32'h05);
		d(48'he0d1);
		c("kind", ifd_pkg::IFD_K_SHIFT, dec.res.kind);
		c("count", 8'h01, dec.shift_count);
		d(48'he0d3);
		c("count", 8'h05, dec.shift_count);
		rd(8'h24);
		c("res2", 32'h05, q);
	endtask : t_shift

	task t_cond;
		logic [15:0] f[5];
		logic [7:0]  o[5];
		logic        t[5];
		f = '{16'h0800, 16'h0800, 16'h0001, 16'h0001, 16'h0040};
		o = '{8'h72, 8'h7c, 8'h72, 8'h7c, 8'h74};
		t = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
		for (int i = 0; i < 5; i++) begin
			wr(8'h10, {16'h0, f[i]});
			d({32'h0, 8'h10, o[i]});
			c("kind", ifd_pkg::IFD_K_JCC, dec.res.kind);
			c("cond", t[i], dec.res.cond_true);
		end
	endtask : t_cond

	task t_pfx;
		d(48'h3e);
		c("kind", ifd_pkg::IFD_K_SEG_PFX, dec.res.kind);
		c("len", 4'h1, dec.res.len);
		rd(8'h18);
		c("seg held", 32'h7, q);
		d(48'h078b);
		c("ovr", 3'h7, {dec.res.seg_ovr, dec.res.seg});
		d(48'h078b);
		c("ovr", 1'b0, dec.res.seg_ovr);
		wr(8'h10, 32'h0040);
		d(48'ha6f3);
		c("kind", ifd_pkg::IFD_K_REP_PFX, dec.res.kind);
		c("rep", 1'b1, dec.res.rep_cont);
		d(48'ha6f2);
		c("rep", 1'b0, dec.res.rep_cont);
	endtask : t_pfx

	task t_rst;
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		c("dec rst", 32'h0, dec.res);
		@(posedge pclk);
		presetn <= 1'b1;
		rd(8'h10);
		c("flags rst", 32'h0, q);
	endtask : t_rst

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		errors = 0;
		checked = 0;
		presetn = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		wr(8'h08, 32'h2000_1000);
		wr(8'h0c, 32'h0400_0030);
		wr(8'h10, 32'h0);
		t_ops();
		t_modes();
		t_reg();
		t_imm();
		t_shift();
		t_cond();
		t_pfx();
		t_rst();
		tally_and_finish();
	end

endmodule : cpu_instruction_field_decoder_test
